// ===== hdl/two_line_interrupt_prioritizer.v
// interrupt prioritizer: 101 sources, 32 channels, fast and normal host lines
// assumes a classic Wishbone master on clk_i and sources in any clock domain
//
// The Wishbone slave port and the register addresses were decided locally.
`include "irq_prio_regs.vh"
module two_line_interrupt_prioritizer #(
	parameter [`N_SRC-1:0] INVERT_MASK = {`N_SRC{1'b0}},
	parameter [`N_SRC-1:0] UNCONN_MASK = `UNCONNECTED_MASK
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire [`N_SRC-1:0] sys_irq_i,
	output reg host_fast_line_o,
	output reg host_normal_line_o
);
	localparam N = `N_SRC;

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	// two flops settle slow sources; the third only feeds the edge detect
	reg [N-1:0] sync1;
	reg [N-1:0] sync2;
	reg [N-1:0] sync3;
	wire [N-1:0] pulse;

	// level sources would re-fire forever without the edge detect
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= {N{1'b0}};
			sync2 <= {N{1'b0}};
			sync3 <= {N{1'b0}};
		end else begin
			sync1 <= (sys_irq_i ^ INVERT_MASK) & ~UNCONN_MASK;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	assign pulse = sync2 & ~sync3;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire req = cyc_i & stb_i & ~ack_o;
	wire wr = req & we_i;
	wire rd = req & ~we_i;
	wire [5:0] widx = adr_i[7:2];
	wire [31:0] lane = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [31:0] wd = dat_i & lane;
	// an out-of-range index write is dropped, never wrapped onto a real source
	wire idx_ok = (wd[31:7] == 25'h0) && (wd[6:0] < N);

	// one strobe per plain register write
	wire wr_cfg = wr && widx == `CFG_REG;
	wire wr_glob = wr && widx == `GLOBAL_EN_REG;
	wire wr_host_en = wr && widx == `HOST_EN_REG;
	wire wr_base = wr && widx == `BASE_REG;
	wire wr_stride = wr && widx == `STRIDE_REG;
	wire wr_null = wr && widx == `NULL_REG;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [N-1:0] en;
	reg [N-1:0] raw;
	reg [1:0] host_en;
	reg glob_en;
	reg freeze_mode;
	reg [31:0] vbase;
	reg [31:0] vstride;
	reg [31:0] vnull;
	// per line results, each driven from its own generate branch
	wire [13:0] win_idx;
	wire [1:0] win_none;
	wire [63:0] win_vec;

	wire [N-1:0] en_pend = raw & en;
	wire [127:0] en128 = {27'h0, en};
	wire [127:0] raw128 = {27'h0, raw};
	wire [127:0] pend128 = {27'h0, en_pend};
	wire [N*5-1:0] cmap_flat;
	wire [1:0] hit;
	wire [13:0] pidx;

	// ----------------------------------------------------------------
	// set and clear strobes
	// ----------------------------------------------------------------
	reg [127:0] en_set;
	reg [127:0] en_clr;
	reg [127:0] pend_clr;
	reg [1:0] host_rel;
	reg [1:0] host_set;
	reg [1:0] host_clr;
	reg [1:0] rd_win;
	integer k;
	integer j;

	always @* begin
		en_set = 128'h0;
		en_clr = 128'h0;
		pend_clr = 128'h0;
		host_rel = 2'b00;
		host_set = 2'b00;
		host_clr = 2'b00;
		rd_win = 2'b00;
		for (k = 0; k < 4; k = k + 1) begin
			if (wr && widx == `SRC_SET_REG0 + k)
				en_set[k*32 +: 32] = wd;
			if (wr && widx == `SRC_CLR_REG0 + k)
				en_clr[k*32 +: 32] = wd;
			if (wr && widx == `PEND_CLR_REG0 + k)
				pend_clr[k*32 +: 32] = wd;
		end
		if (wr && widx == `SRC_IDX_SET_REG && idx_ok)
			en_set[wd[6:0]] = 1'b1;
		if (wr && widx == `SRC_IDX_CLR_REG && idx_ok)
			en_clr[wd[6:0]] = 1'b1;
		if (wr && widx == `PEND_IDX_CLR_REG && idx_ok)
			pend_clr[wd[6:0]] = 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			if (wr && widx == `HOST_IDX_SET_REG && wd == k)
				host_set[k] = 1'b1;
			if (wr && widx == `HOST_IDX_CLR_REG && wd == k)
				host_clr[k] = 1'b1;
			if (wr && (widx == `WIN_IDX_REG0 + k || widx == `WIN_VEC_REG0 + k))
				host_rel[k] = 1'b1;
			if (rd && (widx == `WIN_IDX_REG0 + k || widx == `WIN_VEC_REG0 + k))
				rd_win[k] = 1'b1;
		end
		if (wr_host_en)
			host_rel = host_rel | wd[1:0];
		host_rel = host_rel | host_set | host_clr;
	end

	// ----------------------------------------------------------------
	// register file writes
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			en <= {N{1'b0}};
			raw <= {N{1'b0}};
			host_en <= 2'b00;
			glob_en <= 1'b0;
			freeze_mode <= 1'b0;
			vbase <= 32'h0000_0000;
			vstride <= 32'h0000_0000;
			vnull <= 32'h0000_0000;
		end else begin
			en <= (en & ~en_clr[N-1:0]) | en_set[N-1:0];
			// a new event wins over a clear in the same cycle
			raw <= (raw & ~pend_clr[N-1:0]) | pulse;
			host_en <= (host_en & ~host_clr) | host_set;
			if (wr_host_en)
				host_en <= wd[1:0];
			if (wr_glob)
				glob_en <= wd[0];
			if (wr_cfg)
				freeze_mode <= wd[`CFG_FREEZE_BIT];
			if (wr_base)
				vbase <= (vbase & ~lane) | wd;
			if (wr_stride)
				vstride <= (vstride & ~lane) | wd;
			if (wr_null)
				vnull <= (vnull & ~lane) | wd;
		end
	end

	// ----------------------------------------------------------------
	// channel map: one map register covers four sources
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : map_g
			reg [4:0] ch;
			always @(posedge clk_i) begin
				if (rst_i)
					ch <= 5'h00;
				else if (wr && widx == `CHAN_MAP_REG0 + g / 4 && sel_i[g % 4])
					ch <= dat_i[(g % 4) * 8 +: 5];
			end
			assign cmap_flat[g*5 +: 5] = ch;
		end
	endgenerate

	// ----------------------------------------------------------------
	// per line prioritization and freeze
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < 2; g = g + 1) begin : line_g
			reg frozen;
			reg [6:0] idx_q;
			reg none_q;
			reg [31:0] vec_q;
			wire [31:0] prod = vstride * {25'h0, pidx[g*7 +: 7]};
			// freezing in the read cycle keeps the value read equal to the one held
			wire hold = frozen | (freeze_mode & rd_win[g]);
			line_prio_pick #(
				.N_SRC(N),
				.CH_LO(g * 2),
				.CH_HI(g == 0 ? 1 : `N_CHAN - 1)
			) pick (
				.act_i(en_pend),
				.cmap_i(cmap_flat),
				.hit_o(hit[g]),
				.idx_o(pidx[g*7 +: 7])
			);
			// a freeze outlives clearing the mode bit; only the release writes end it
			always @(posedge clk_i) begin
				if (rst_i) begin
					frozen <= 1'b0;
					idx_q <= 7'h00;
					none_q <= 1'b1;
					vec_q <= 32'h0000_0000;
				end else begin
					frozen <= host_rel[g] ? 1'b0 : hold;
					if (!hold) begin
						idx_q <= hit[g] ? pidx[g*7 +: 7] : 7'h00;
						none_q <= ~hit[g];
						vec_q <= hit[g] ? vbase + prod : vnull;
					end
				end
			end
			assign win_idx[g*7 +: 7] = idx_q;
			assign win_none[g] = none_q;
			assign win_vec[g*32 +: 32] = vec_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// host lines
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			host_fast_line_o <= 1'b0;
			host_normal_line_o <= 1'b0;
		end else begin
			host_fast_line_o <= glob_en & host_en[0] & hit[0];
			host_normal_line_o <= glob_en & host_en[1] & hit[1];
		end
	end

	// ----------------------------------------------------------------
	// read mux and acknowledge
	// ----------------------------------------------------------------
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0000_0000;
		if (widx >= `CHAN_MAP_REG0 && widx < `CHAN_MAP_REG0 + `CHAN_MAP_REGS) begin
			for (j = 0; j < 4; j = j + 1) begin
				if ((widx - `CHAN_MAP_REG0) * 4 + j < N)
					rdata[j*8 +: 5] = cmap_flat[((widx - `CHAN_MAP_REG0) * 4 + j) * 5 +: 5];
			end
		end else begin
			case (widx)
				`CFG_REG: rdata[`CFG_FREEZE_BIT] = freeze_mode;
				`GLOBAL_EN_REG: rdata[0] = glob_en;
				`HOST_EN_REG: rdata[1:0] = host_en;
				`SRC_SET_REG0, `SRC_CLR_REG0: rdata = en128[31:0];
				`SRC_SET_REG0 + 1, `SRC_CLR_REG0 + 1: rdata = en128[63:32];
				`SRC_SET_REG0 + 2, `SRC_CLR_REG0 + 2: rdata = en128[95:64];
				`SRC_SET_REG0 + 3, `SRC_CLR_REG0 + 3: rdata = en128[127:96];
				`PEND_CLR_REG0: rdata = pend128[31:0];
				`PEND_CLR_REG0 + 1: rdata = pend128[63:32];
				`PEND_CLR_REG0 + 2: rdata = pend128[95:64];
				`PEND_CLR_REG0 + 3: rdata = pend128[127:96];
				`RAW_STAT_REG0: rdata = raw128[31:0];
				`RAW_STAT_REG0 + 1: rdata = raw128[63:32];
				`RAW_STAT_REG0 + 2: rdata = raw128[95:64];
				`RAW_STAT_REG0 + 3: rdata = raw128[127:96];
				`BASE_REG: rdata = vbase;
				`STRIDE_REG: rdata = vstride;
				`NULL_REG: rdata = vnull;
				`WIN_IDX_REG0: begin
					rdata[6:0] = win_idx[6:0];
					rdata[`NONE_PEND_BIT] = win_none[0];
				end
				`WIN_IDX_REG0 + 1: begin
					rdata[6:0] = win_idx[13:7];
					rdata[`NONE_PEND_BIT] = win_none[1];
				end
				`WIN_VEC_REG0: rdata = win_vec[31:0];
				`WIN_VEC_REG0 + 1: rdata = win_vec[63:32];
				default: rdata = 32'h0000_0000;
			endcase
		end
	end

	// unmapped or write-only words answer with zero so the bus never hangs
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			dat_o <= rd ? rdata : 32'h0000_0000;
		end
	end
endmodule // two_line_interrupt_prioritizer

// ===== hdl/irq_prio_regs.vh
// register offsets and field layout of the two-line interrupt prioritizer
// assumes a 32-bit classic Wishbone slave; offsets are word indices (byte addr = 4 * index)
// ----------------------------------------------------------------
// Notes on behaviour
// - inputs are synchronised, made active high and turned into pulses
// - one global enable gates both host lines, each also has its own enable
// - host line enabled by setting its enable bit or writing its index 0-1
// - source enabled by set registers or by writing its index 0-100
// - raw pending ignores enable; enabled pending reads zero while disabled
// - enabled pending of 101 sources is read as four 32-bit words
// - pending bit latches on event, stays until cleared, clears bit by bit
// - 32 channels, channel 0 highest priority, channel 31 lowest
// - a channel is active while any source mapped to it is active
// - channel per source set in 26 map registers, four sources each
// - channels 0-1 drive the fast line, 2-31 the normal line, fixed
// - per line the lowest numbered active channel wins
// - within that channel the lowest source index wins
// - winner index per line tracks continuously unless frozen
// - in freeze mode a read of index or vector freezes both of that line
// - unconnected source numbers are treated as always inactive
// - writes to index, vector or host index registers release freeze; a host enable write releases only lines whose bit is written 1
// - vector is base plus index times stride, null address when nothing pends
// - pending N clears by bit N of clear registers or index N write
// - source N disabled by bit N of clear registers or index N write
// ----------------------------------------------------------------
`ifndef IRQ_PRIO_REGS_VH
`define IRQ_PRIO_REGS_VH
`define N_SRC 101
`define N_CHAN 32
`define CFG_REG 6'h00
`define GLOBAL_EN_REG 6'h01
`define HOST_EN_REG 6'h02
`define HOST_IDX_SET_REG 6'h03
`define HOST_IDX_CLR_REG 6'h04
`define SRC_IDX_SET_REG 6'h05
`define SRC_IDX_CLR_REG 6'h06
`define PEND_IDX_CLR_REG 6'h07
`define SRC_SET_REG0 6'h08
`define SRC_CLR_REG0 6'h0C
`define PEND_CLR_REG0 6'h10
`define RAW_STAT_REG0 6'h14
`define BASE_REG 6'h18
`define STRIDE_REG 6'h19
`define NULL_REG 6'h1A
`define WIN_IDX_REG0 6'h1C
`define WIN_VEC_REG0 6'h1E
`define CHAN_MAP_REG0 6'h20
`define CHAN_MAP_REGS 26
`define CFG_FREEZE_BIT 0
`define NONE_PEND_BIT 31
`define UNCONNECTED_MASK 101'h8_5800_01FE_0400_0000
`endif

// ===== hdl/line_prio_pick.v
// two-level winner search for one host line
// assumes act is already enabled-and-pending; purely combinational
module line_prio_pick #(
	parameter N_SRC = 101,
	parameter CH_LO = 0,
	parameter CH_HI = 1
) (
	input wire [N_SRC-1:0] act_i,
	input wire [N_SRC*5-1:0] cmap_i,
	output reg hit_o,
	output reg [6:0] idx_o
);
	reg [31:0] ch_act;
	reg [4:0] win_ch;
	integer c;
	integer i;

	// ----------------------------------------------------------------
	// channel activity and first level
	// ----------------------------------------------------------------
	always @* begin
		ch_act = 32'h0000_0000;
		for (i = 0; i < N_SRC; i = i + 1) begin
			ch_act[cmap_i[i*5 +: 5]] = ch_act[cmap_i[i*5 +: 5]] | act_i[i];
		end
		hit_o = 1'b0;
		win_ch = 5'h00;
		// descending scan so the lowest numbered channel is left last
		for (c = CH_HI; c >= CH_LO; c = c - 1) begin
			if (ch_act[c]) begin
				hit_o = 1'b1;
				win_ch = c[4:0];
			end
		end
		// ----------------------------------------------------------------
		// second level: lowest source inside the winning channel
		// ----------------------------------------------------------------
		idx_o = 7'h00;
		for (i = N_SRC - 1; i >= 0; i = i - 1) begin
			if (act_i[i] && cmap_i[i*5 +: 5] == win_ch)
				idx_o = i[6:0];
		end
	end
endmodule // line_prio_pick

// ===== verification/irq_prio_assertions.sv
// port checker for the two-line prioritizer
// assumes one clock and a synchronous active-high reset
module irq_prio_checker (
	input logic clk_i,
	input logic rst_i,
	input logic cyc_i,
	input logic stb_i,
	input logic we_i,
	input logic [7:0] adr_i,
	input logic [3:0] sel_i,
	input logic [31:0] dat_i,
	input logic [31:0] dat_o,
	input logic ack_o,
	input logic [100:0] sys_irq_i,
	input logic host_fast_line_o,
	input logic host_normal_line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---
	// bus and line properties
	// ---
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire req = cyc_i && stb_i && !ack_o;
	wire wr = req && we_i && sel_i[0];
	wire [5:0] wa = adr_i[7:2];
	wire f = host_fast_line_o;
	wire n = host_normal_line_o;
	property p_ack_next; req |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	property p_ack_drop; ack_o |=> !ack_o; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
	property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_rst_quiet; $fell(rst_i) |-> !ack_o && !f && !n; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs up after reset");
	property p_glb_off; wr && wa == 6'h01 && !dat_i[0] |=> ##1 !f && !n; endproperty
	a_glb_off: assert property (p_glb_off) else $error("line up, global off");
	property p_fast_off; wr && wa == 6'h02 && !dat_i[0] |=> ##1 !f; endproperty
	a_fast_off: assert property (p_fast_off) else $error("fast line up, disabled");
	property p_norm_off; wr && wa == 6'h02 && !dat_i[1] |=> ##1 !n; endproperty
	a_norm_off: assert property (p_norm_off) else $error("normal line up, disabled");
	// pending only goes away through a register write, so a line never drops by itself
	property p_fast_hold; $fell(f) |-> $past(req && we_i, 2) || $past(rst_i); endproperty
	a_fast_hold: assert property (p_fast_hold) else $error("fast line fell alone");
	property p_norm_hold; $fell(n) |-> $past(req && we_i, 2) || $past(rst_i); endproperty
	a_norm_hold: assert property (p_norm_hold) else $error("normal line fell alone");
endmodule // irq_prio_checker

bind two_line_interrupt_prioritizer irq_prio_checker i_irq_prio_checker (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sys_irq_i(sys_irq_i),
	.host_fast_line_o(host_fast_line_o), .host_normal_line_o(host_normal_line_o));

// ===== verification/host_core_model.sv
// host core model: takes one interrupt in each cycle in which either host line rises
// assumes level lines registered on the same clock
module host_core_model (
	input logic clk_i,
	input logic rst_i,
	input logic fast_i,
	input logic norm_i,
	output int takes_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic f_q = 1'b0;
	logic n_q = 1'b0;
	always @(posedge clk_i) begin
		f_q <= fast_i;
		n_q <= norm_i;
		if (rst_i) takes_o <= 0;
		else if ((fast_i && !f_q) || (norm_i && !n_q)) takes_o <= takes_o + 1;
	end
endmodule // host_core_model

// ===== verification/two_line_interrupt_prioritizer_tb.sv
// self-checking bench for the two-line prioritizer
// assumes the design and its header on the include path
`include "irq_prio_regs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module two_line_interrupt_prioritizer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [100:0] UNC = `UNCONNECTED_MASK;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, gen = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, base = 32'h0, strd = 32'h0, nul = 32'h0, dat_o, q;
	logic ack_o, host_fast_line_o, host_normal_line_o;
	logic [100:0] sys_irq_i = 101'h0, rawp = 101'h0, en = 101'h0;
	logic [4:0] chn [101];
	logic [1:0] hen = 2'h0;
	int miscompares = 0, compares = 0, takes;
	two_line_interrupt_prioritizer i_two_line_interrupt_prioritizer (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sys_irq_i(sys_irq_i),
		.host_fast_line_o(host_fast_line_o), .host_normal_line_o(host_normal_line_o));
	host_core_model i_host_core_model (.clk_i(clk_i), .rst_i(rst_i),
		.fast_i(host_fast_line_o), .norm_i(host_normal_line_o), .takes_o(takes));
	initial forever #4 clk_i = ~clk_i;
	// ---
	// bus, stimulus and reference
	// ---
	task test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {a, 2'b00};
		dat_i <= d;
		sel_i <= s;
		do @(posedge clk_i);
		while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task rd(input logic [5:0] a);
		wb(1'b0, a, 32'h0, 4'hF);
	endtask
	// writes a value or a one-hot word bit and tracks what it does
	task op(input logic [5:0] a, input int s, input bit word);
		if (word) wb(1'b1, a + 6'(s / 32), 32'h1 << (s % 32), 4'hF);
		else wb(1'b1, a, 32'(s), 4'hF);
		case (a)
			`SRC_IDX_SET_REG, `SRC_SET_REG0: en[s] = 1'b1;
			`SRC_IDX_CLR_REG, `SRC_CLR_REG0: en[s] = 1'b0;
			`PEND_IDX_CLR_REG, `PEND_CLR_REG0: rawp[s] = 1'b0;
			`GLOBAL_EN_REG: gen = s[0];
			`HOST_EN_REG: hen = s[1:0];
			`HOST_IDX_SET_REG: hen[s] = 1'b1;
			`HOST_IDX_CLR_REG: hen[s] = 1'b0;
			default: ;
		endcase
	endtask
	// byte lane write so the neighbours' channels are left alone
	task map(input int s, input int c);
		wb(1'b1, `CHAN_MAP_REG0 + 6'(s / 4), 32'(c) << (8 * (s % 4)), 4'h1 << (s % 4));
		chn[s] = 5'(c);
	endtask
	task pulse(input int s);
		@(posedge clk_i);
		sys_irq_i[s] <= 1'b1;
		@(posedge clk_i);
		sys_irq_i[s] <= 1'b0;
		if (!UNC[s]) rawp[s] = 1'b1;
		repeat (8) @(posedge clk_i);
	endtask
	function int pick();
		int s;
		do s = $urandom % 101; while (UNC[s]);
		return s;
	endfunction
	function logic [31:0] exp_idx(input int l);
		for (int c = 0; c < 32; c++)
			for (int s = 0; s < 101; s++)
				if (rawp[s] && en[s] && chn[s] == c && (c < 2) == (l == 0)) return 32'(s);
		return 32'h80000000;
	endfunction
	task chk;
		logic [31:0] e;
		for (int l = 0; l < 2; l++) begin
			e = exp_idx(l);
			rd(`WIN_IDX_REG0 + 6'(l));
			`CHK(q, e)
			rd(`WIN_VEC_REG0 + 6'(l));
			`CHK(q, e[31] ? nul : base + e * strd)
			`CHK(l ? host_normal_line_o : host_fast_line_o, gen & hen[l] & !e[31])
		end
		for (int w = 0; w < 4; w++) begin
			rd(`PEND_CLR_REG0 + 6'(w));
			`CHK(q, 32'((rawp & en) >> (32 * w)))
			rd(`RAW_STAT_REG0 + 6'(w));
			`CHK(q, 32'(rawp >> (32 * w)))
		end
	endtask
	task trial(input int t);
		int s1, s2;
		s1 = t == 0 ? 100 : t == 1 ? 4 : pick();
		s2 = t == 0 ? 0 : t == 1 ? 3 : pick();
		map(s1, t == 0 ? 0 : t == 1 ? 31 : $urandom % 32);
		map(s2, t == 0 ? 1 : t == 1 ? 31 : $urandom % 32);
		pulse(s2);
		op(`SRC_IDX_SET_REG, s1, 0);
		chk;
		op(`SRC_SET_REG0, s2, 1);
		pulse(s1);
		chk;
		op(`PEND_IDX_CLR_REG, s1, 0);
		chk;
		op(`PEND_CLR_REG0, s2, 1);
		op(`SRC_IDX_CLR_REG, s1, 0);
		op(`SRC_CLR_REG0, s2, 1);
		chk;
	endtask
	initial begin
		repeat (60000) @(posedge clk_i);
		miscompares++;
		test_done;
	end
	initial begin
		for (int s = 0; s < 101; s++) chn[s] = 5'h00;
		void'($urandom(89));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`CFG_REG);
		`CHK(q, 32'h0)
		chk;
		base = $urandom;
		strd = $urandom;
		nul = $urandom;
		wb(1'b1, `BASE_REG, base, 4'hF);
		wb(1'b1, `STRIDE_REG, strd, 4'hF);
		wb(1'b1, `NULL_REG, nul, 4'hF);
		op(`HOST_EN_REG, 1, 0);
		op(`HOST_IDX_SET_REG, 1, 0);
		op(`GLOBAL_EN_REG, 1, 0);
		op(`SRC_IDX_SET_REG, 59, 0);
		pulse(59);
		for (int t = 0; t < 24; t++) trial(t);
		map(5, 3);
		op(`SRC_IDX_SET_REG, 5, 0);
		pulse(5);
		wb(1'b1, `CFG_REG, 32'h1, 4'hF);
		rd(`WIN_VEC_REG0 + 6'h01);
		op(`PEND_IDX_CLR_REG, 5, 0);
		rd(`WIN_IDX_REG0 + 6'h01);
		`CHK(q, 32'h5)
		op(`HOST_IDX_SET_REG, 1, 0);
		rd(`WIN_IDX_REG0 + 6'h01);
		`CHK(q, 32'h80000000)
		pulse(5);
		rd(`WIN_IDX_REG0 + 6'h01);
		`CHK(q, 32'h80000000)
		wb(1'b1, `WIN_IDX_REG0 + 6'h01, 32'h0, 4'hF);
		rd(`WIN_IDX_REG0 + 6'h01);
		`CHK(q, 32'h5)
		wb(1'b1, `CFG_REG, 32'h0, 4'hF);
		map(7, 0);
		op(`SRC_SET_REG0, 7, 1);
		pulse(7);
		chk;
		op(`GLOBAL_EN_REG, 0, 0);
		chk;
		op(`GLOBAL_EN_REG, 1, 0);
		op(`HOST_EN_REG, 2, 0);
		chk;
		op(`HOST_IDX_SET_REG, 0, 0);
		chk;
		op(`HOST_IDX_CLR_REG, 0, 0);
		chk;
		op(`HOST_IDX_SET_REG, 0, 0);
		op(`PEND_CLR_REG0, 7, 1);
		chk;
		// a level held high must give one event only
		@(posedge clk_i);
		sys_irq_i[9] <= 1'b1;
		repeat (8) @(posedge clk_i);
		rawp[9] = 1'b1;
		rd(`RAW_STAT_REG0);
		`CHK(q, 32'(rawp))
		op(`PEND_IDX_CLR_REG, 9, 0);
		repeat (8) @(posedge clk_i);
		chk;
		sys_irq_i[9] <= 1'b0;
		`CHK(takes > 0, 1'b1)
		test_done;
	end
endmodule // two_line_interrupt_prioritizer_tb
